// ### rtl/spdif_in_pkg.sv
package spdif_in_pkg;

    typedef enum logic [1:0] {
        FMT_I2S,
        FMT_LEFT,
        FMT_RIGHT
    } fmt_t;

    typedef enum logic [1:0] {
        WIDTH_16,
        WIDTH_18,
        WIDTH_20,
        WIDTH_24
    } width_t;

    localparam int SAMPLE_W = 24;
    localparam int SLOT_CLOCKS = 32;
    localparam int FRAME_CLOCKS = 64;
    localparam logic [5:0] I2S_DELAY = 6'h01;
    localparam logic [5:0] LEFT_DELAY = 6'h00;
    localparam logic [5:0] RJ_DELAY_16 = 6'h10;
    localparam logic [5:0] RJ_DELAY_18 = 6'h0E;
    localparam logic [5:0] RJ_DELAY_20 = 6'h0C;
    localparam logic [5:0] RJ_DELAY_24 = 6'h08;
    localparam logic [5:0] BITS_16 = 6'h10;
    localparam logic [5:0] BITS_18 = 6'h12;
    localparam logic [5:0] BITS_20 = 6'h14;
    localparam logic [5:0] BITS_24 = 6'h18;

    localparam int OSR_384 = 384;
    localparam int OSR_256 = 256;
    localparam int BIPHASE_PER_FRAME = 128;
    localparam int DPLL_RATIO = 512;
    localparam int SCLK_RATIO = 64;
    localparam int FRAME_RATE_MAX_HZ = 192000;

    typedef struct packed {
        logic right;
        logic [SAMPLE_W-1:0] sample;
    } audio_word_t;

endpackage

// ### rtl/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    always_comb begin
        in_ready = (cnt_r != (AW+1)'(DEPTH));
        out_valid = (cnt_r != '0);
        push = in_valid && in_ready && clk_en;
        pop = out_valid && out_ready && clk_en;
        wr_nxt = push ? ((wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1) : wr_r;
        rd_nxt = pop ? ((rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1) : rd_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        out_data = mem[rd_r];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end
endmodule // word_fifo

// ### rtl/biphase_clock_divider.sv
`timescale 1ns/1ps
module biphase_clock_divider (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic oversample_tx_clock,
    input wire logic osr_384,
    output logic biphase_tick
);
    // The oversampling clock is sampled, so it must stay below half of ref_clk.
    localparam logic [1:0] LAST_384 = 2'(spdif_in_pkg::OSR_384 / spdif_in_pkg::BIPHASE_PER_FRAME - 1);
    localparam logic [1:0] LAST_256 = 2'(spdif_in_pkg::OSR_256 / spdif_in_pkg::BIPHASE_PER_FRAME - 1);
    logic [1:0] sync_r, sync_nxt;
    logic prev_r, prev_nxt;
    logic [1:0] div_r, div_nxt;
    logic tick_r, tick_nxt;
    logic rise;

    always_comb begin
        sync_nxt = {sync_r[0], oversample_tx_clock};
        prev_nxt = sync_r[1];
        rise = sync_r[1] && !prev_r;
        div_nxt = div_r;
        tick_nxt = 1'b0;
        if (rise) begin
            // 384/128 = 3 and 256/128 = 2 input edges per biphase cell.
            if (div_r == (osr_384 ? LAST_384 : LAST_256)) begin
                div_nxt = 2'h0;
                tick_nxt = 1'b1;
            end else begin
                div_nxt = div_r + 2'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_r <= 2'h0;
            prev_r <= 1'b0;
            div_r <= 2'h0;
            tick_r <= 1'b0;
        end else if (clk_en) begin
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign biphase_tick = tick_r;
endmodule // biphase_clock_divider

// ### rtl/serial_input_formatter.sv
`timescale 1ns/1ps
module serial_input_formatter #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic enable,
    input wire spdif_in_pkg::fmt_t fmt,
    input wire spdif_in_pkg::width_t width,
    input wire logic osr_384,
    input wire logic serial_clock,
    input wire logic frame_sync,
    input wire logic serial_data,
    input wire logic oversample_tx_clock,
    input wire logic dpll_mode,
    output logic biphase_tick,
    output logic recovery_tick,
    output logic rx_serial_clock,
    output logic word_valid,
    input wire logic word_ready,
    output spdif_in_pkg::audio_word_t word_data,
    output logic overflow
);
    localparam int WORD_W = $bits(spdif_in_pkg::audio_word_t);

    // Two-stage synchronisers; stage one feeds only stage two.
    // Each serial clock level must be seen by two samples, so that clock has to stay below a
    // quarter of ref_clk. Sync history resets low; a source idling high makes one false edge
    // at its first clock, and the real slot edge that follows simply restarts the capture.
    logic [1:0] sck_s_r, sck_s_nxt, fs_s_r, fs_s_nxt, sd_s_r, sd_s_nxt;
    logic sck_prev_r, sck_prev_nxt;
    logic fs_prev_r, fs_prev_nxt;
    logic sck_rise;
    logic fs_edge;

    always_comb begin
        sck_s_nxt = {sck_s_r[0], serial_clock};
        fs_s_nxt = {fs_s_r[0], frame_sync};
        sd_s_nxt = {sd_s_r[0], serial_data};
        sck_prev_nxt = sck_s_r[1];
        sck_rise = sck_s_r[1] && !sck_prev_r;
        fs_prev_nxt = sck_rise ? fs_s_r[1] : fs_prev_r;
        fs_edge = sck_rise && (fs_s_r[1] != fs_prev_r);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sck_s_r <= 2'h0;
            fs_s_r <= 2'h0;
            sd_s_r <= 2'h0;
            sck_prev_r <= 1'b0;
            fs_prev_r <= 1'b0;
        end else if (clk_en) begin
            sck_s_r <= sck_s_nxt;
            fs_s_r <= fs_s_nxt;
            sd_s_r <= sd_s_nxt;
            sck_prev_r <= sck_prev_nxt;
            fs_prev_r <= fs_prev_nxt;
        end
    end

    // Word capture: the count runs in serial clocks since the last sync edge up to the delay, then restarts to count shifted bits.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SKIP,
        ST_SHIFT,
        ST_WAIT
    } cap_state_t;

    cap_state_t st_r, st_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [5:0] delay, nbits;
    logic [spdif_in_pkg::SAMPLE_W-1:0] shreg_r, shreg_nxt;
    logic right_r, right_nxt;
    logic push;
    spdif_in_pkg::audio_word_t push_word;
    logic fifo_ready;
    logic ovf_r, ovf_nxt;
    logic chan_right;
    spdif_in_pkg::fmt_t fmt_r, fmt_nxt;
    spdif_in_pkg::width_t width_r, width_nxt;

    // Format and width are taken over only while no word is being shifted, so a change
    // cannot tear a word in flight; it applies from the next sync edge.
    always_comb begin
        fmt_nxt = fmt_r;
        width_nxt = width_r;
        if (st_r == ST_IDLE || st_r == ST_WAIT) begin
            fmt_nxt = fmt;
            width_nxt = width;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fmt_r <= spdif_in_pkg::FMT_I2S;
            width_r <= spdif_in_pkg::WIDTH_24;
        end else if (clk_en) begin
            fmt_r <= fmt_nxt;
            width_r <= width_nxt;
        end
    end

    always_comb begin
        case (width_r)
            spdif_in_pkg::WIDTH_16: nbits = spdif_in_pkg::BITS_16;
            spdif_in_pkg::WIDTH_18: nbits = spdif_in_pkg::BITS_18;
            spdif_in_pkg::WIDTH_20: nbits = spdif_in_pkg::BITS_20;
            default: nbits = spdif_in_pkg::BITS_24;
        endcase
        case (fmt_r)
            spdif_in_pkg::FMT_LEFT: delay = spdif_in_pkg::LEFT_DELAY;
            spdif_in_pkg::FMT_RIGHT: begin
                case (width_r)
                    spdif_in_pkg::WIDTH_16: delay = spdif_in_pkg::RJ_DELAY_16;
                    spdif_in_pkg::WIDTH_18: delay = spdif_in_pkg::RJ_DELAY_18;
                    spdif_in_pkg::WIDTH_20: delay = spdif_in_pkg::RJ_DELAY_20;
                    default: delay = spdif_in_pkg::RJ_DELAY_24;
                endcase
            end
            default: delay = spdif_in_pkg::I2S_DELAY;
        endcase
        // Level of sync after its transition names the channel of the new word.
        if (fmt_r == spdif_in_pkg::FMT_I2S) begin
            chan_right = fs_s_r[1];
        end else begin
            chan_right = !fs_s_r[1];
        end
    end

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        shreg_nxt = shreg_r;
        right_nxt = right_r;
        push = 1'b0;
        ovf_nxt = ovf_r;
        if (!enable) begin
            st_nxt = ST_IDLE;
        end else if (fs_edge) begin
            // The sync edge clock is itself serial clock zero of the slot.
            right_nxt = chan_right;
            shreg_nxt = '0;
            if (delay == 6'h00) begin
                shreg_nxt = {{(spdif_in_pkg::SAMPLE_W-1){1'b0}}, sd_s_r[1]};
                cnt_nxt = 6'h01;
                st_nxt = ST_SHIFT;
            end else begin
                cnt_nxt = 6'h01;
                st_nxt = ST_SKIP;
            end
            if (delay == 6'h00 && nbits == 6'h01) begin
                st_nxt = ST_WAIT;
            end
        end else if (sck_rise) begin
            case (st_r)
                ST_SKIP: begin
                    if (cnt_r == delay) begin
                        shreg_nxt = {shreg_r[spdif_in_pkg::SAMPLE_W-2:0], sd_s_r[1]};
                        cnt_nxt = 6'h01;
                        st_nxt = ST_SHIFT;
                    end else begin
                        cnt_nxt = cnt_r + 6'h01;
                    end
                end
                ST_SHIFT: begin
                    shreg_nxt = {shreg_r[spdif_in_pkg::SAMPLE_W-2:0], sd_s_r[1]};
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r + 6'h01 == nbits) begin
                        push = 1'b1;
                        ovf_nxt = ovf_r || !fifo_ready;
                        st_nxt = ST_WAIT;
                    end
                end
                default: st_nxt = st_r;
            endcase
        end
        push_word.right = right_r;
        // Words are MSB-aligned within the sample field.
        push_word.sample = shreg_nxt << (6'(spdif_in_pkg::SAMPLE_W) - nbits);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r <= ST_IDLE;
            cnt_r <= 6'h00;
            shreg_r <= '0;
            right_r <= 1'b0;
            ovf_r <= 1'b0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            shreg_r <= shreg_nxt;
            right_r <= right_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    // A word that meets a full buffer is dropped whole and the older words are kept;
    // overflow then stays set until reset so software cannot miss the loss.
    assign overflow = ovf_r;

    word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(push_word),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );

    biphase_clock_divider u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .oversample_tx_clock(oversample_tx_clock),
        .osr_384(osr_384),
        .biphase_tick(biphase_tick)
    );

    // Receiver DPLL mode: a free ratio generator locks 512x and 64x to each frame.
    // Without a real PLL the periods come from the measured frame length.
    logic [15:0] frame_len_r, frame_len_nxt, frame_cnt_r, frame_cnt_nxt;
    logic [15:0] rec_acc_r, rec_acc_nxt;
    logic [8:0] rec_div_r, rec_div_nxt;
    logic rec_tick_r, rec_tick_nxt;
    logic rxsck_r, rxsck_nxt;
    logic fs_lvl_r, fs_lvl_nxt;

    always_comb begin
        fs_lvl_nxt = fs_s_r[1];
        // The counter sticks at its top value so a lost sync cannot wrap to a short frame.
        frame_cnt_nxt = frame_cnt_r + 16'(frame_cnt_r != '1);
        frame_len_nxt = frame_len_r;
        if (fs_s_r[1] && !fs_lvl_r) begin
            // The cycle of the sync edge itself belongs to the frame that it closes.
            frame_len_nxt = frame_cnt_r + 16'h0001;
            frame_cnt_nxt = 16'h0000;
        end
        // At most one tick per cycle: frames shorter than DPLL_RATIO cycles are not followed.
        rec_tick_nxt = 1'b0;
        rec_acc_nxt = rec_acc_r + 16'(spdif_in_pkg::DPLL_RATIO);
        rec_div_nxt = rec_div_r;
        rxsck_nxt = rxsck_r;
        if (rec_acc_nxt >= frame_len_r && frame_len_r != 16'h0000) begin
            rec_acc_nxt = rec_acc_nxt - frame_len_r;
            rec_tick_nxt = 1'b1;
            // 512/64 = 8 recovery ticks per serial clock, toggling every 4.
            rec_div_nxt = rec_div_r + 9'h001;
            if (rec_div_r[1:0] == 2'h3) begin
                rxsck_nxt = !rxsck_r;
            end
        end
        if (!dpll_mode) begin
            rec_tick_nxt = 1'b0;
            rxsck_nxt = 1'b0;
            rec_acc_nxt = 16'h0000;
            rec_div_nxt = 9'h000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            frame_len_r <= 16'h0000;
            frame_cnt_r <= 16'h0000;
            rec_acc_r <= 16'h0000;
            rec_div_r <= 9'h000;
            rec_tick_r <= 1'b0;
            rxsck_r <= 1'b0;
            fs_lvl_r <= 1'b0;
        end else if (clk_en) begin
            frame_len_r <= frame_len_nxt;
            frame_cnt_r <= frame_cnt_nxt;
            rec_acc_r <= rec_acc_nxt;
            rec_div_r <= rec_div_nxt;
            rec_tick_r <= rec_tick_nxt;
            rxsck_r <= rxsck_nxt;
            fs_lvl_r <= fs_lvl_nxt;
        end
    end

    assign recovery_tick = rec_tick_r;
    assign rx_serial_clock = rxsck_r;
endmodule // serial_input_formatter

// ### verification/serial_input_formatter_asserts.sv
`timescale 1ns/1ps
module serial_input_formatter_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic oversample_tx_clock,
    input wire logic dpll_mode,
    input wire logic biphase_tick,
    input wire logic recovery_tick,
    input wire logic rx_serial_clock,
    input wire logic word_valid,
    input wire logic word_ready,
    input wire spdif_in_pkg::audio_word_t word_data,
    input wire logic overflow
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [4:0] quiet_r, quiet_nxt, off_r, off_nxt;
    logic [2:0] pace_r, pace_nxt;
    logic osc_r, rxs_r;
    // Counts saturate, so a long idle stretch cannot wrap round to a small value.
    always_comb begin
        quiet_nxt = (oversample_tx_clock != osc_r) ? 5'h00 : quiet_r + 5'(quiet_r != 5'h1F);
        off_nxt = enable ? 5'h00 : off_r + 5'(off_r != 5'h1F);
        pace_nxt = (rx_serial_clock != rxs_r) ? 3'h0 : pace_r + 3'(recovery_tick && pace_r != 3'h7);
    end
    always_ff @(posedge ref_clk) begin
        osc_r <= oversample_tx_clock;
        rxs_r <= rx_serial_clock;
        quiet_r <= rst ? 5'h00 : quiet_nxt;
        off_r <= rst ? 5'h00 : off_nxt;
        pace_r <= rst ? 3'h0 : pace_nxt;
    end
    sequence held_word;
        word_valid && !word_ready;
    endsequence
    sequence osc_still;
        quiet_r >= 5'h08;
    endsequence
    chk_word_held: assert property (held_word |=> word_valid && $stable(word_data))
        else $error("word changed before acceptance");
    chk_ovf_sticky: assert property (overflow |=> overflow)
        else $error("overflow flag cleared");
    chk_ovf_full: assert property ($rose(overflow) |-> word_valid)
        else $error("overflow with empty buffer");
    chk_off_no_word: assert property ($rose(word_valid) |-> off_r < 5'h0C)
        else $error("word captured while disabled");
    chk_tick_single: assert property (biphase_tick |=> !biphase_tick)
        else $error("biphase tick longer than a cycle");
    chk_tick_cause: assert property (osc_still |-> !biphase_tick)
        else $error("biphase tick without oversampling clock");
    chk_dpll_idle: assert property ((!dpll_mode) [*3] |-> !recovery_tick)
        else $error("recovery tick outside pll mode");
    chk_sclk_pace: assert property (pace_r <= 3'h5)
        else $error("receiver serial clock too slow");
endmodule // serial_input_formatter_asserts

bind serial_input_formatter serial_input_formatter_asserts chk (.ref_clk, .rst, .enable,
    .oversample_tx_clock, .dpll_mode, .biphase_tick, .recovery_tick, .rx_serial_clock,
    .word_valid, .word_ready, .word_data, .overflow);

// ### verification/audio_source.sv
`timescale 1ns/1ps
module audio_source (
    input wire logic ref_clk,
    output logic serial_clock,
    output logic frame_sync,
    output logic serial_data
);
    initial begin
        serial_clock = 1'b0;
        frame_sync = 1'b1;
        serial_data = 1'b0;
    end
    // One serial period is eight reference cycles; sync and data are set while it is low, and data flips again while it is high.
    task automatic bit_cycle(input logic fs, input logic d);
        @(posedge ref_clk);
        serial_clock <= 1'b0;
        frame_sync <= fs;
        serial_data <= d;
        repeat (4) @(posedge ref_clk);
        serial_clock <= 1'b1;
        repeat (2) @(posedge ref_clk);
        // Data goes bad halfway through the high phase, so only rising-edge capture sees it.
        serial_data <= ~d;
        @(posedge ref_clk);
    endtask
    task automatic send(input spdif_in_pkg::fmt_t fmt, input spdif_in_pkg::width_t width,
                        input logic [23:0] lw, input logic [23:0] rw);
        int nb, dly, idx;
        logic lft;
        nb = (width == spdif_in_pkg::WIDTH_24) ? 24 : 16 + 2 * int'(width);
        dly = 32 - nb;
        if (fmt == spdif_in_pkg::FMT_I2S) dly = 1;
        if (fmt == spdif_in_pkg::FMT_LEFT) dly = 0;
        lft = (fmt != spdif_in_pkg::FMT_I2S);
        // A lead-in pulse at the right level makes sure the left slot opens with a sync edge.
        bit_cycle(~lft, ~serial_data);
        for (int k = 0; k < 64; k++) begin
            idx = k % 32 - dly;
            if (idx >= 0 && idx < nb) bit_cycle(lft ^ (k >= 32), (k < 32) ? lw[23-idx] : rw[23-idx]);
            else bit_cycle(lft ^ (k >= 32), ~serial_data);
        end
        @(posedge ref_clk);
        serial_clock <= 1'b0;
        serial_data <= ~serial_data;
    endtask
endmodule // audio_source

// ### verification/tb_serial_input_formatter.sv
`timescale 1ns/1ps
module tb_serial_input_formatter;
    logic ref_clk, rst, enable, osr_384, oversample_tx_clock, dpll_mode, word_ready, osc_on;
    logic serial_clock, frame_sync, serial_data, biphase_tick, recovery_tick, clk_en;
    logic rx_serial_clock, word_valid, overflow, rx_prev;
    spdif_in_pkg::fmt_t fmt;
    spdif_in_pkg::width_t width;
    spdif_in_pkg::audio_word_t word_data;
    spdif_in_pkg::audio_word_t got[$];
    int fails, checked, cycles, n_bip, n_rec, n_flip;

    serial_input_formatter dut (.ref_clk, .rst, .clk_en, .enable, .fmt, .width, .osr_384,
        .serial_clock, .frame_sync, .serial_data, .oversample_tx_clock, .dpll_mode, .biphase_tick,
        .recovery_tick, .rx_serial_clock, .word_valid, .word_ready, .word_data, .overflow);
    audio_source src (.ref_clk, .serial_clock, .frame_sync, .serial_data);

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        n_bip += biphase_tick;
        n_rec += recovery_tick;
        n_flip += int'(rx_serial_clock != rx_prev);
        rx_prev = rx_serial_clock;
        if (osc_on && cycles % 2 == 0) oversample_tx_clock <= ~oversample_tx_clock;
        if (word_valid === 1'b1 && word_ready === 1'b1) got.push_back(word_data);
        if (cycles > 40000) begin
            fails++;
            conclude();
        end
    end

    task automatic cmp(input string what, input logic [24:0] exp, input logic [24:0] seen);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Captured samples are MSB aligned with the unused low bits cleared.
    function automatic logic [24:0] expect_word(input logic ch, input logic [23:0] v);
        int nb;
        nb = (width == spdif_in_pkg::WIDTH_24) ? 24 : 16 + 2 * int'(width);
        return {ch, v & (24'hFFFFFF << (24 - nb))};
    endfunction

    task automatic t_formats();
        word_ready <= 1'b1;
        for (int f = 0; f < 3; f++) begin
            for (int w = 0; w < 4; w++) begin
                fmt <= spdif_in_pkg::fmt_t'(f);
                width <= spdif_in_pkg::width_t'(w);
                @(posedge ref_clk);
                got.delete();
                src.send(fmt, width, 24'hB4E1D7 ^ 24'(w), 24'h4B1E28 ^ 24'(f));
                repeat (16) @(posedge ref_clk);
                cmp("word count", 25'h02, 25'(got.size()));
                cmp("left word", expect_word(1'b0, 24'hB4E1D7 ^ 24'(w)), got[0]);
                cmp("right word", expect_word(1'b1, 24'h4B1E28 ^ 24'(f)), got[1]);
            end
        end
        got.delete();
    endtask

    task automatic t_disabled();
        enable <= 1'b0;
        @(posedge ref_clk);
        src.send(fmt, width, 24'h123456, 24'h654321);
        repeat (16) @(posedge ref_clk);
        cmp("words while disabled", 25'h00, 25'(got.size()));
        enable <= 1'b1;
    endtask

    task automatic t_overflow();
        fmt <= spdif_in_pkg::FMT_I2S;
        width <= spdif_in_pkg::WIDTH_24;
        word_ready <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 4; i++) src.send(fmt, width, 24'hA00000 + 24'(i), 24'h500000);
        repeat (16) @(posedge ref_clk);
        cmp("full buffer valid", 25'h01, {24'h0, word_valid});
        cmp("no overflow at depth", 25'h00, {24'h0, overflow});
        src.send(fmt, width, 24'hFFFFFF, 24'h000000);
        repeat (16) @(posedge ref_clk);
        cmp("overflow after loss", 25'h01, {24'h0, overflow});
        word_ready <= 1'b1;
        repeat (16) @(posedge ref_clk);
        cmp("drained words", 25'h08, 25'(got.size()));
        cmp("oldest word", expect_word(1'b0, 24'hA00000), got[0]);
        cmp("empty after drain", 25'h00, {24'h0, word_valid});
        got.delete();
    endtask

    task automatic t_biphase(input logic sel, input int exp);
        osr_384 <= sel;
        osc_on <= 1'b1;
        repeat (8) @(posedge ref_clk);
        n_bip = 0;
        repeat (384) @(posedge ref_clk);
        osc_on <= 1'b0;
        cmp("biphase ticks near ratio", 25'h01, 25'(n_bip inside {[exp-1:exp+1]}));
    endtask

    task automatic t_freeze();
        clk_en <= 1'b0;
        osc_on <= 1'b1;
        repeat (8) @(posedge ref_clk);
        n_bip = 0;
        repeat (64) @(posedge ref_clk);
        osc_on <= 1'b0;
        clk_en <= 1'b1;
        cmp("ticks while frozen", 25'h00, 25'(n_bip));
    endtask

    task automatic t_dpll();
        dpll_mode <= 1'b1;
        repeat (2) src.send(fmt, width, 24'h0F0F0F, 24'hF0F0F0);
        n_rec = 0;
        n_flip = 0;
        src.send(fmt, width, 24'h0F0F0F, 24'hF0F0F0);
        dpll_mode <= 1'b0;
        cmp("recovery ticks per frame", 25'h01, 25'(n_rec inside {[500:524]}));
        cmp("serial clock edges per frame", 25'h01, 25'(n_flip inside {[124:132]}));
        got.delete();
    endtask

    initial begin
        rst = 1'b1;
        enable = 1'b1;
        fmt = spdif_in_pkg::FMT_I2S;
        width = spdif_in_pkg::WIDTH_24;
        osr_384 = 1'b1;
        oversample_tx_clock = 1'b0;
        dpll_mode = 1'b0;
        word_ready = 1'b1;
        osc_on = 1'b0;
        clk_en = 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        cmp("valid after reset", 25'h00, {24'h0, word_valid});
        t_formats();
        t_disabled();
        t_overflow();
        t_biphase(1'b1, 32);
        t_biphase(1'b0, 48);
        t_freeze();
        t_dpll();
        conclude();
    end
endmodule // tb_serial_input_formatter
